// file: hw/rdc_regs.svh
/*
  constants for the run command and dwell control block.
  assumes a 10 mhz clock; settings arrive as plain ports.
*/
`ifndef RDC_REGS_SVH
`define RDC_REGS_SVH
`define RDC_CLK_HZ 10_000_000
`define RDC_SRC_PANEL 1'h0
`define RDC_SRC_TERM 1'h1
`define RDC_SRC_RESET 1'h1
`define RDC_STOP_RAMP 1'h0
`define RDC_STOP_COAST 1'h1
`define RDC_STOP_RESET 1'h0
`define RDC_RDP_IGNORE 2'h0
`define RDC_RDP_ACCEPT 2'h1
`define RDC_RDP_LOCK 2'h2
`define RDC_RDP_RESET 2'h1
`define RDC_PHASE_STD 1'h0
`define RDC_PHASE_SWAP 1'h1
`define RDC_PHASE_RESET 1'h0
`define RDC_DWELL_SPD_RESET 10'h000
`define RDC_DWELL_SPD_FULL 10'h3E8
`define RDC_TENTH_S_NS 100_000_000
`define RDC_CLK_NS 100
`define RDC_TENTH_S_CYC (`RDC_TENTH_S_NS / `RDC_CLK_NS)
`define RDC_HUNDREDTH_S_CYC 32'h0001_86A0
`define RDC_DWELL_TIME_MAX 7'h64
`endif

// file: hw/rdc_pkg.sv
/*
  types for the run command and dwell control block.
  assumes rdc_regs.svh for numeric constants.
*/
package rdc_pkg;
  typedef enum logic [2:0] {
    RDC_IDLE = 3'b000,
    RDC_ACCEL = 3'b001,
    RDC_DWELL_START = 3'b010,
    RDC_RUN = 3'b011,
    RDC_DECEL = 3'b100,
    RDC_DWELL_STOP = 3'b101
  } rdc_state_t;

  // speed in 0.1 % units, times in 0.1 s units, ramp in 0.01 s units
  typedef struct packed {
    logic command_source_select;
    logic stop_method_select;
    logic [1:0] run_during_programming_select;
    logic phase_order_select;
    logic [9:0] start_dwell_speed;
    logic [6:0] start_dwell_time;
    logic [9:0] stop_dwell_speed;
    logic [6:0] stop_dwell_time;
    logic [15:0] decel_ramp_one_time;
    logic [15:0] accel_ramp_one_time;
  } rdc_cfg_t;

  typedef struct packed {
    logic up;
    logic down;
    logic stop;
  } rdc_cmd_t;
endpackage : rdc_pkg

// file: hw/rdc_ramp_step.sv
/*
  ramp step generator: one pulse each time the reference moves one unit.
  assumes time settings in 0.01 s for full scale travel.
*/
`timescale 1ns/1ps
`include "rdc_regs.svh"
module rdc_ramp_step #(
  parameter int unsigned FULL = 1000
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // control
  input wire logic active,
  input wire logic [15:0] ramp_time,
  output logic step
);
  // full scale ramp of t*0.01 s over FULL units: t*100000/FULL cycles per unit
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic [31:0] limit;

  if (FULL == 0) begin : g_full_check
    $error("FULL must be nonzero");
  end

  always_comb begin
    // 64 bit product: long ramps overflow 32 bits before the divide
    limit = 32'((64'(ramp_time) * 64'(`RDC_HUNDREDTH_S_CYC)) / 64'(FULL));
    cnt_nxt = cnt_r;
    step = 1'b0;
    if (!active) begin
      cnt_nxt = '0;
    end else if (cnt_r + 32'h0000_0001 >= limit) begin
      cnt_nxt = '0;
      step = 1'b1;
    end else begin
      cnt_nxt = cnt_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule : rdc_ramp_step

// file: hw/rdc_run_control.sv
/*
  run command source, stop method, programming lock, phase order and dwell.
  assumes all inputs synchronous to mclk; panel mode reported by the panel.
*/
`timescale 1ns/1ps
`include "rdc_regs.svh"

//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - source 0 takes panel commands, 1 takes terminal commands; terminal default.
// - stop method 0: run removal or stop ramps speed to zero on decel ramp one.
// - stop method 1: run removal cuts motor output at once, motor coasts.
// - verify, setup, parameter and auto-tune panel modes count as programming.
// - run-during-programming 0 ignores run commands while panel programs.
// - run-during-programming 1, the default, accepts run in every panel mode.
// - run-during-programming 2 refuses programming entry while output active.
// - phase order 0 standard, 1 swapped, reversing motor direction.
// - accelerating, hold reference at start dwell speed for start dwell time.
// - decelerating, hold reference at a nonzero stop dwell speed for stop dwell time.
// - dwell speeds are 0 to 100 percent of maximum; both default zero.
// - decel ramp value is time from maximum speed down to zero.
module rdc_run_control
  import rdc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  // settings
  input wire rdc_pkg::rdc_cfg_t cfg,
  // commands
  input wire rdc_pkg::rdc_cmd_t panel_cmd,
  input wire rdc_pkg::rdc_cmd_t term_cmd,
  // panel mode requests
  input wire logic panel_verify_req,
  input wire logic panel_setup_req,
  input wire logic panel_param_req,
  input wire logic panel_autotune_req,
  // status and drive
  output logic programming_mode,
  output logic programming_refused,
  output logic output_active,
  output logic dir_up,
  output logic phase_swapped,
  output logic [9:0] speed_ref,
  output logic [2:0] run_state
);
  import rdc_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_s1_r;
  logic rst_n;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n <= rst_s1_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // command selection and gating
  rdc_state_t state_r, state_nxt;
  logic src_r, src_nxt;
  logic phase_r, phase_nxt;
  logic up_dir_r, up_dir_nxt;
  logic [9:0] spd_r, spd_nxt;
  logic [31:0] dwell_cnt_r, dwell_cnt_nxt;
  logic prog_req;
  logic prog_ok;
  rdc_cmd_t cmd;
  logic run_req;
  logic run_ok;
  logic step;
  logic ramping;

  function automatic logic [31:0] tenths_to_cyc(input logic [6:0] t);
    tenths_to_cyc = 32'(t) * 32'(`RDC_TENTH_S_CYC);
  endfunction : tenths_to_cyc

  assign output_active = (state_r != RDC_IDLE);
  // the four panel programming screens
  assign prog_req = panel_verify_req | panel_setup_req | panel_param_req
                    | panel_autotune_req;
  // lock keeps the operator out of programming while the drive runs
  assign prog_ok = !(cfg.run_during_programming_select == `RDC_RDP_LOCK
                     && output_active);
  assign programming_mode = prog_req & prog_ok;
  assign programming_refused = prog_req & !prog_ok;
  assign cmd = (src_r == `RDC_SRC_PANEL) ? panel_cmd : term_cmd;
  assign run_req = (cmd.up ^ cmd.down) & !cmd.stop;
  // setting 1 and 2 accept; 0 drops commands during programming
  assign run_ok = run_req
                  && !(programming_mode
                       && cfg.run_during_programming_select == `RDC_RDP_IGNORE);
  assign ramping = (state_r == RDC_ACCEL) || (state_r == RDC_DECEL);

  rdc_ramp_step #(
    .FULL(int'(`RDC_DWELL_SPD_FULL))
  ) u_step (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .active(ramping),
    .ramp_time((state_r == RDC_DECEL) ? cfg.decel_ramp_one_time
                                      : cfg.accel_ramp_one_time),
    .step(step)
  );

  //////////////////////////////////////////////////////////////////////////
  // run sequencer
  always_comb begin
    state_nxt = state_r;
    src_nxt = src_r;
    phase_nxt = phase_r;
    up_dir_nxt = up_dir_r;
    spd_nxt = spd_r;
    dwell_cnt_nxt = dwell_cnt_r;
    case (state_r)
      RDC_IDLE: begin
        // settings latched only while stopped
        src_nxt = cfg.command_source_select;
        phase_nxt = cfg.phase_order_select;
        spd_nxt = '0;
        dwell_cnt_nxt = '0;
        if (run_ok) begin
          up_dir_nxt = cmd.up;
          state_nxt = RDC_ACCEL;
        end
      end
      RDC_ACCEL: begin
        if (!run_ok) begin
          dwell_cnt_nxt = '0;
          if (cfg.stop_method_select == `RDC_STOP_COAST) begin
            state_nxt = RDC_IDLE;
          end else begin
            state_nxt = RDC_DECEL;
          end
        end else if (spd_r == cfg.start_dwell_speed && dwell_cnt_r == '0
                     && cfg.start_dwell_time != '0) begin
          state_nxt = RDC_DWELL_START;
        end else if (spd_r >= `RDC_DWELL_SPD_FULL) begin
          state_nxt = RDC_RUN;
        end else if (step) begin
          spd_nxt = spd_r + 10'h001;
          dwell_cnt_nxt = '0;
        end
      end
      RDC_DWELL_START: begin
        if (!run_ok) begin
          state_nxt = (cfg.stop_method_select == `RDC_STOP_COAST) ? RDC_IDLE
                                                                 : RDC_DECEL;
          dwell_cnt_nxt = '0;
        end else if (dwell_cnt_r + 32'h0000_0001
                     >= tenths_to_cyc(cfg.start_dwell_time)) begin
          // counter left nonzero so the hold is not re-entered
          state_nxt = RDC_ACCEL;
          dwell_cnt_nxt = 32'h0000_0001;
          spd_nxt = (spd_r < `RDC_DWELL_SPD_FULL) ? spd_r + 10'h001 : spd_r;
        end else begin
          dwell_cnt_nxt = dwell_cnt_r + 32'h0000_0001;
        end
      end
      RDC_RUN: begin
        if (!run_ok) begin
          state_nxt = (cfg.stop_method_select == `RDC_STOP_COAST) ? RDC_IDLE
                                                                 : RDC_DECEL;
          dwell_cnt_nxt = '0;
        end
      end
      RDC_DECEL: begin
        if (cfg.stop_method_select == `RDC_STOP_COAST && !run_ok) begin
          state_nxt = RDC_IDLE;
        end else if (spd_r == cfg.stop_dwell_speed && dwell_cnt_r == '0
                     && cfg.stop_dwell_time != '0 && spd_r != '0) begin
          state_nxt = RDC_DWELL_STOP;
        end else if (spd_r == '0) begin
          state_nxt = RDC_IDLE;
        end else if (step) begin
          spd_nxt = spd_r - 10'h001;
        end
      end
      RDC_DWELL_STOP: begin
        if (dwell_cnt_r + 32'h0000_0001 >= tenths_to_cyc(cfg.stop_dwell_time)) begin
          state_nxt = RDC_DECEL;
          dwell_cnt_nxt = 32'h0000_0001;
          spd_nxt = spd_r - 10'h001;
        end else begin
          dwell_cnt_nxt = dwell_cnt_r + 32'h0000_0001;
        end
      end
      default: state_nxt = RDC_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= RDC_IDLE;
      src_r <= `RDC_SRC_RESET;
      phase_r <= `RDC_PHASE_RESET;
      up_dir_r <= 1'b1;
      spd_r <= `RDC_DWELL_SPD_RESET;
      dwell_cnt_r <= '0;
    end else if (ce) begin
      state_r <= state_nxt;
      src_r <= src_nxt;
      phase_r <= phase_nxt;
      up_dir_r <= up_dir_nxt;
      spd_r <= spd_nxt;
      dwell_cnt_r <= dwell_cnt_nxt;
    end
  end

  // swapped phase order turns an up command into reverse rotation
  assign dir_up = up_dir_r ^ (phase_r == `RDC_PHASE_SWAP);
  assign phase_swapped = phase_r;
  assign speed_ref = spd_r;
  assign run_state = state_r;

  //////////////////////////////////////////////////////////////////////////
  // checks
  property p_coast;
    @(posedge mclk) disable iff (!rst_n)
      (ce && output_active && state_r != RDC_DWELL_STOP && !run_ok
       && cfg.stop_method_select == `RDC_STOP_COAST) |=> !output_active;
  endproperty
  a_coast: assert property (p_coast) else $error("coast stop kept output");

  property p_ramp_stop;
    @(posedge mclk) disable iff (!rst_n)
      (ce && state_r inside {RDC_ACCEL, RDC_DWELL_START, RDC_RUN} && !run_ok
       && cfg.stop_method_select == `RDC_STOP_RAMP) |=> state_r == RDC_DECEL;
  endproperty
  a_ramp_stop: assert property (p_ramp_stop) else $error("ramp stop missed");

  property p_prog_lock;
    @(posedge mclk) disable iff (!rst_n)
      (cfg.run_during_programming_select == `RDC_RDP_LOCK && output_active)
        |-> !programming_mode;
  endproperty
  a_prog_lock: assert property (p_prog_lock) else $error("programming while running");

  property p_prog_ignore;
    @(posedge mclk) disable iff (!rst_n)
      (ce && state_r == RDC_IDLE && programming_mode
       && cfg.run_during_programming_select == `RDC_RDP_IGNORE) |=> state_r == RDC_IDLE;
  endproperty
  a_prog_ignore: assert property (p_prog_ignore) else $error("run during programming");

  property p_src_hold;
    @(posedge mclk) disable iff (!rst_n)
      (ce && output_active) |=> $stable(src_r) && $stable(phase_r);
  endproperty
  a_src_hold: assert property (p_src_hold) else $error("setting changed while running");

  property p_dir;
    @(posedge mclk) disable iff (!rst_n)
      (ce && state_r == RDC_IDLE && run_ok) |=> dir_up == ($past(cmd.up) ^ phase_swapped);
  endproperty
  a_dir: assert property (p_dir) else $error("direction not per phase order");

  sequence s_start_dwell;
    state_r == RDC_DWELL_START;
  endsequence
  property p_start_hold;
    @(posedge mclk) disable iff (!rst_n)
      s_start_dwell |-> speed_ref == cfg.start_dwell_speed;
  endproperty
  a_start_hold: assert property (p_start_hold) else $error("start dwell speed wrong");

  property p_stop_hold;
    @(posedge mclk) disable iff (!rst_n)
      (state_r == RDC_DWELL_STOP && ce) |=> speed_ref == $past(speed_ref)
        || state_r == RDC_DECEL;
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stop dwell not held");

  property p_linear;
    @(posedge mclk) disable iff (!rst_n)
      (ce && state_r == RDC_ACCEL && state_nxt == RDC_ACCEL && !step)
        |=> $stable(speed_ref);
  endproperty
  a_linear: assert property (p_linear) else $error("speed moved without step");
endmodule : rdc_run_control

// file: bench/rdc_elev_ctrl.sv
/*
  model of the elevator controller that drives the run command terminals.
  assumes the bench names the wanted command and how many cycles to lag.
*/
`timescale 1ns/1ps
module rdc_elev_ctrl
  import rdc_pkg::*;
(
  // clock
  input wire logic mclk,
  // wanted command and answer lag
  input wire rdc_pkg::rdc_cmd_t want,
  input wire logic [3:0] lag,
  // terminals
  output rdc_pkg::rdc_cmd_t term_cmd
);
  logic [3:0] wait_r = 4'h0;
  initial term_cmd = '0;
  // levels move just after the edge; a lag mimics slow relay contacts
  always @(posedge mclk) begin
    if (want != term_cmd && wait_r < lag) begin
      wait_r <= wait_r + 4'h1;
    end else begin
      term_cmd <= want;
      wait_r <= 4'h0;
    end
  end
endmodule : rdc_elev_ctrl

// file: bench/run_command_dwell_control_bench.sv
/*
  self-checking bench for the run command and dwell control block.
  assumes hw/ on the include path and the controller model compiled first.
*/
`timescale 1ns/1ps
`include "rdc_regs.svh"
module run_command_dwell_control_bench;
  import rdc_pkg::*;
  localparam rdc_cmd_t C_UP = 3'h4;
  localparam rdc_cmd_t C_DN = 3'h2;
  localparam rdc_cmd_t C_UPSTOP = 3'h5;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  rdc_cfg_t cfg;
  rdc_cmd_t panel_cmd = '0;
  rdc_cmd_t want = '0;
  rdc_cmd_t term_cmd;
  logic [3:0] lag = 4'h0;
  logic [3:0] preq = 4'h0;
  logic programming_mode, programming_refused, output_active, dir_up, phase_swapped;
  logic [9:0] speed_ref;
  logic [2:0] run_state;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #50 mclk = ~mclk;
  rdc_run_control u_rdc_run_control (.mclk(mclk), .resetn(resetn), .ce(ce), .cfg(cfg),
    .panel_cmd(panel_cmd), .term_cmd(term_cmd), .panel_verify_req(preq[0]),
    .panel_setup_req(preq[1]), .panel_param_req(preq[2]), .panel_autotune_req(preq[3]),
    .programming_mode(programming_mode), .programming_refused(programming_refused),
    .output_active(output_active), .dir_up(dir_up), .phase_swapped(phase_swapped),
    .speed_ref(speed_ref), .run_state(run_state));
  rdc_elev_ctrl u_rdc_elev_ctrl (.mclk(mclk), .want(want), .lag(lag), .term_cmd(term_cmd));
  //////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask : tick
  // generous ceiling: the longest scenario needs a few thousand cycles
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      end_sim();
    end
  end
  task automatic do_reset();
    @(negedge mclk);
    resetn = 1'b0;
    tick(20);
    resetn = 1'b1;
    tick(4);
  endtask : do_reset
  // one extra edge after the terminals settle so the block has sampled them
  task automatic send_term(input rdc_cmd_t c);
    want = c;
    for (int i = 0; i < 20 && term_cmd !== c; i++) tick(1);
    tick(1);
  endtask : send_term
  task automatic wait_state(input logic [2:0] s, input int bound, output int n);
    n = 0;
    while (run_state !== s && n < bound) begin
      tick(1);
      n++;
    end
  endtask : wait_state
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_source();
    send_term(C_UP);
    check("terminal run by default", output_active, 1);
    cfg.stop_method_select = `RDC_STOP_COAST;
    send_term('0);
    check("coast to idle", run_state, RDC_IDLE);
    cfg.command_source_select = `RDC_SRC_PANEL;
    tick(2);
    send_term(C_UP);
    tick(1);
    check("terminal ignored", output_active, 0);
    send_term('0);
    panel_cmd = C_UPSTOP;
    tick(2);
    check("stop beats up", output_active, 0);
    panel_cmd = C_UP;
    tick(2);
    check("panel run", output_active, 1);
    panel_cmd = '0;
    tick(1);
    check("panel coast", run_state, RDC_IDLE);
    cfg.command_source_select = `RDC_SRC_TERM;
    tick(2);
  endtask : t_source
  task automatic t_prog();
    for (int i = 0; i < 4; i++) begin
      preq = 4'(1 << i);
      tick(1);
      check("programming screen", programming_mode, 1);
    end
    lag = 4'h3;
    cfg.run_during_programming_select = `RDC_RDP_IGNORE;
    send_term(C_UP);
    tick(2);
    check("run while programming", output_active, 0);
    cfg.run_during_programming_select = `RDC_RDP_ACCEPT;
    tick(2);
    check("run accepted", output_active, 1);
    cfg.run_during_programming_select = `RDC_RDP_LOCK;
    tick(1);
    check("locked mode", programming_mode, 0);
    check("locked refused", programming_refused, 1);
    send_term('0);
    tick(1);
    check("idle mode", programming_mode, 1);
    check("idle refused", programming_refused, 0);
    preq = 4'h0;
    lag = 4'h0;
    cfg.run_during_programming_select = `RDC_RDP_ACCEPT;
  endtask : t_prog
  task automatic t_phase();
    cfg.phase_order_select = `RDC_PHASE_SWAP;
    tick(2);
    send_term(C_UP);
    check("swapped flag", phase_swapped, 1);
    check("up reversed", dir_up, 0);
    cfg.phase_order_select = `RDC_PHASE_STD;
    cfg.command_source_select = `RDC_SRC_PANEL;
    tick(3);
    check("phase held running", phase_swapped, 1);
    check("source held running", output_active, 1);
    cfg.command_source_select = `RDC_SRC_TERM;
    send_term('0);
    tick(2);
    check("phase taken idle", phase_swapped, 0);
    send_term(C_DN);
    check("down standard", dir_up, 0);
    send_term('0);
  endtask : t_phase
  // zero ramp times step every cycle, so full speed is reached quickly
  task automatic t_full();
    int n;
    cfg.stop_method_select = `RDC_STOP_RAMP;
    cfg.accel_ramp_one_time = 16'h0000;
    cfg.decel_ramp_one_time = 16'h0000;
    send_term(C_UP);
    tick(10);
    ce = 1'b0;
    tick(20);
    check("frozen by enable", speed_ref, 16'h000A);
    ce = 1'b1;
    wait_state(RDC_RUN, 1200, n);
    check("full speed", speed_ref, `RDC_DWELL_SPD_FULL);
    check("accel time", 16'(n inside {[980:1000]}), 1);
    send_term(C_UPSTOP);
    check("stop command ramps", run_state, RDC_DECEL);
    wait_state(RDC_IDLE, 1200, n);
    check("ramped to zero", speed_ref, 16'h0000);
    check("decel time", 16'(n inside {[990:1010]}), 1);
    send_term('0);
    cfg.accel_ramp_one_time = 16'h0001;
    cfg.decel_ramp_one_time = 16'h0001;
  endtask : t_full
  task automatic t_dwell();
    int n;
    cfg.stop_method_select = `RDC_STOP_RAMP;
    cfg.start_dwell_speed = 10'h005;
    cfg.start_dwell_time = 7'h01;
    cfg.stop_dwell_speed = 10'h003;
    cfg.stop_dwell_time = 7'h01;
    send_term(C_UP);
    check("accelerating", run_state, RDC_ACCEL);
    wait_state(RDC_DWELL_START, 800, n);
    check("start dwell", run_state, RDC_DWELL_START);
    check("start dwell speed", speed_ref, 10'h005);
    check("accel slope", 16'(n inside {[350:520]}), 1);
    tick(2000);
    check("start dwell held", speed_ref, 10'h005);
    send_term('0);
    check("ramp stop", run_state, RDC_DECEL);
    wait_state(RDC_DWELL_STOP, 400, n);
    check("stop dwell", run_state, RDC_DWELL_STOP);
    check("stop dwell speed", speed_ref, 10'h003);
    check("decel slope", 16'(n inside {[150:260]}), 1);
    tick(1000);
    check("stop dwell held", run_state, RDC_DWELL_STOP);
    do_reset();
    check("idle after reset", speed_ref, 10'h000);
  endtask : t_dwell
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    cfg = '0;
    cfg.command_source_select = `RDC_SRC_RESET;
    cfg.run_during_programming_select = `RDC_RDP_RESET;
    cfg.accel_ramp_one_time = 16'h0001;
    cfg.decel_ramp_one_time = 16'h0001;
    do_reset();
    check("reset phase", phase_swapped, 0);
    check("reset dir", dir_up, 1);
    t_source();
    t_prog();
    t_phase();
    t_full();
    t_dwell();
    end_sim();
  end
endmodule : run_command_dwell_control_bench
